// >>> src/eeprom_pkg.sv
// constants and types for the serial eeprom command engine
// assumes a single core clock; serial pins arrive unsynchronised
package eeprom_pkg;
  // ---------------------------------------------------------------
  // command bytes (bit 3 is don't-care or address bit 8)
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_MASK          = 8'hf7;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] CMD_READ          = 8'h03;
  localparam logic [7:0] CMD_WRITE         = 8'h02;
  localparam logic [7:0] CMD_SET_WL        = 8'h06;
  localparam logic [7:0] CMD_CLR_WL        = 8'h04;
  localparam int         A8_POS            = 3;
  // ---------------------------------------------------------------
  // status byte layout
  // ---------------------------------------------------------------
  localparam logic [3:0] STAT_ONES         = 4'hf;
  localparam int         STAT_ONES_POS     = 4;
  localparam int         BP_LO_POS         = 2;
  localparam int         WL_POS            = 1;
  localparam int         BUSY_POS          = 0;
  localparam logic [1:0] BP_RESET          = 2'b00;
  // ---------------------------------------------------------------
  // array, page and timing
  // ---------------------------------------------------------------
  localparam int         ADDR_W_DEFAULT    = 9;
  localparam int         PAGE_BYTES        = 16;
  localparam int         PAGE_BITS         = 4;
  localparam logic [7:0] ERASED            = 8'hff;
  localparam int         CLK_PERIOD_NS     = 100;
  localparam int         PROGRAM_TIME_US   = 5000;
  localparam int         PROGRAM_CYCLES    = PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_CMD    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_RDATA  = 3'b010,
    ST_RSTAT  = 3'b011,
    ST_WSDATA = 3'b100,
    ST_ARMED  = 3'b101,
    ST_WDATA  = 3'b110,
    ST_DEAD   = 3'b111
  } state_type;

  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_WL_SET = 2'b01,
    OP_WL_CLR = 2'b10,
    OP_STATUS = 2'b11
  } op_type;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic hold_n;
  } pins_type;

  typedef struct packed {
    logic [PAGE_BYTES-1:0]      valid;
    logic [PAGE_BYTES-1:0][7:0] data;
  } page_type;
endpackage

// >>> src/nv_array.sv
// nonvolatile byte array with a page commit port
// assumes commit only while no read is served
`timescale 1ns/1ps
module nv_array #(
  parameter int ADDR_W = 9
) (
  // clock
  input  wire logic                   core_clk_i,
  // read port
  input  wire logic [ADDR_W-1:0]      rd_addr_i,
  output logic      [7:0]             rd_data_o,
  // page commit
  input  wire logic                   commit_i,
  input  wire logic [ADDR_W-5:0]      base_i,
  input  wire eeprom_pkg::page_type   page_i
);
  logic [7:0] mem [2**ADDR_W];

  // delivery state: every byte erased
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      mem[i] = eeprom_pkg::ERASED;
    end
  end

  assign rd_data_o = mem[rd_addr_i];

  // only bytes loaded into the page buffer are programmed
  always_ff @(posedge core_clk_i) begin
    if (commit_i) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (page_i.valid[i]) begin
          mem[{base_i, 4'(i)}] <= page_i.data[i];
        end
      end
    end
  end
endmodule // nv_array

// >>> src/pin_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes the pins are quasi-static relative to core_clk_i
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // reset to all ones: select reads high, which masks every edge until real pin levels arrive
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // pin_sync

// >>> src/serial_eeprom_command_engine.sv
// serial eeprom command engine: status, read, byte/page write, hold
// assumes serial pins are asynchronous and far slower than core_clk_i
`timescale 1ns/1ps
module serial_eeprom_command_engine #(
  parameter int          ADDR_W         = eeprom_pkg::ADDR_W_DEFAULT,
  parameter int unsigned PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // serial port pins
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  input  wire logic hold_n_i,
  output logic      so_o,
  output logic      so_oe_o
);
  // ---------------------------------------------------------------
  // pin sampling and edges
  // ---------------------------------------------------------------
  eeprom_pkg::pins_type  pin_raw;
  eeprom_pkg::pins_type  pin_s;
  eeprom_pkg::state_type state_r;
  eeprom_pkg::op_type    op_r;
  eeprom_pkg::page_type  page_r;
  logic                  sck_q_r;
  logic                  cs_q_r;
  logic                  hold_r;
  logic [2:0]            bit_cnt_r;
  logic [7:0]            rx_r;
  logic [7:0]            rx_nxt;
  logic [7:0]            cmd_w;
  logic                  a8_r;
  logic                  wr_mode_r;
  logic [ADDR_W-1:0]     addr_r;
  logic [ADDR_W-1:0]     addr_w;
  logic [ADDR_W-1:0]     rd_addr_w;
  logic [7:0]            mem_rd_w;
  logic [7:0]            tx_r;
  logic [2:0]            tx_idx_r;
  logic                  tx_arm_r;
  logic                  drive_r;
  logic                  so_r;
  logic [1:0]            bp_r;
  logic [1:0]            new_bp_r;
  logic                  wel_r;
  logic                  busy_r;
  logic                  kind_mem_r;
  logic [31:0]           prog_cnt_r;
  logic [7:0]            status_w;
  logic                  rise_ok;
  logic                  fall_ok;
  logic                  cs_rise;
  logic                  byte_done;
  logic                  start_stat_w;
  logic                  start_mem_w;
  logic                  prog_end_w;
  logic                  commit_w;

  assign pin_raw = '{cs_n: cs_n_i, sck: sck_i, si: si_i, wp_n: wp_n_i, hold_n: hold_n_i};

  pin_sync #(
    .W (5)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .d_i        (pin_raw),
    .q_o        (pin_s)
  );

  // previous levels match the synchroniser's reset value, so no false edge follows reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sck_q_r <= 1'b1;
      cs_q_r  <= 1'b1;
    end else begin
      sck_q_r <= pin_s.sck;
      cs_q_r  <= pin_s.cs_n;
    end
  end

  // hold follows the pin while the clock is low, so a change made
  // with the clock high lands on the next falling edge
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || pin_s.cs_n) begin
      hold_r <= 1'b0;
    end else if (!pin_s.sck) begin
      hold_r <= ~pin_s.hold_n;
    end
  end

  // clock edges are dead while held; a fall that enters hold is dropped
  assign rise_ok   = ~pin_s.cs_n & ~hold_r & pin_s.sck & ~sck_q_r;
  assign fall_ok   = ~pin_s.cs_n & ~hold_r & pin_s.hold_n & ~pin_s.sck & sck_q_r;
  assign cs_rise   = pin_s.cs_n & ~cs_q_r;
  assign rx_nxt    = {rx_r[6:0], pin_s.si};
  assign byte_done = rise_ok & (bit_cnt_r == 3'd7);
  assign cmd_w     = rx_nxt & eeprom_pkg::CMD_MASK;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] full_addr(input logic a8, input logic [7:0] lo);
    logic [8:0] a;
    a = {a8, lo};
    return a[ADDR_W-1:0];
  endfunction

  function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    logic hit;
    hit = 1'b0;
    case (bp)
      2'b01:   hit = (a[ADDR_W-1 -: 2] == 2'b11);
      2'b10:   hit = a[ADDR_W-1];
      2'b11:   hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  always_comb begin
    status_w = {eeprom_pkg::STAT_ONES, 4'h0};
    status_w[eeprom_pkg::BP_LO_POS +: 2] = bp_r;
    status_w[eeprom_pkg::WL_POS]         = wel_r;
    status_w[eeprom_pkg::BUSY_POS]       = busy_r;
  end

  // ---------------------------------------------------------------
  // bit counter and receive shifter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || pin_s.cs_n) begin
      bit_cnt_r <= 3'd0;
      rx_r      <= 8'h00;
    end else if (rise_ok) begin
      bit_cnt_r <= bit_cnt_r + 3'd1;
      rx_r      <= rx_nxt;
    end
  end

  assign addr_w    = full_addr(a8_r, rx_nxt);
  assign rd_addr_w = (state_r == eeprom_pkg::ST_ADDR) ? addr_w : ADDR_W'(addr_r + 1'b1);

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || pin_s.cs_n) begin
      state_r <= eeprom_pkg::ST_CMD;
      op_r    <= eeprom_pkg::OP_NONE;
    end else if (byte_done) begin
      case (state_r)
        eeprom_pkg::ST_CMD: begin
          a8_r <= rx_nxt[eeprom_pkg::A8_POS];
          if (busy_r && cmd_w != eeprom_pkg::CMD_READ_STATUS) begin
            state_r <= eeprom_pkg::ST_DEAD;
          end else if (cmd_w == eeprom_pkg::CMD_READ_STATUS) begin
            state_r <= eeprom_pkg::ST_RSTAT;
          end else if (cmd_w == eeprom_pkg::CMD_WRITE_STATUS) begin
            state_r <= (wel_r && pin_s.wp_n) ? eeprom_pkg::ST_WSDATA : eeprom_pkg::ST_DEAD;
          end else if (cmd_w == eeprom_pkg::CMD_READ) begin
            state_r   <= eeprom_pkg::ST_ADDR;
            wr_mode_r <= 1'b0;
          end else if (cmd_w == eeprom_pkg::CMD_WRITE) begin
            state_r   <= (wel_r && pin_s.wp_n) ? eeprom_pkg::ST_ADDR : eeprom_pkg::ST_DEAD;
            wr_mode_r <= 1'b1;
          end else if (cmd_w == eeprom_pkg::CMD_SET_WL) begin
            state_r <= eeprom_pkg::ST_ARMED;
            op_r    <= eeprom_pkg::OP_WL_SET;
          end else if (cmd_w == eeprom_pkg::CMD_CLR_WL) begin
            state_r <= eeprom_pkg::ST_ARMED;
            op_r    <= eeprom_pkg::OP_WL_CLR;
          end else begin
            state_r <= eeprom_pkg::ST_DEAD;
          end
        end
        eeprom_pkg::ST_ADDR: begin
          addr_r <= addr_w;
          if (!wr_mode_r) begin
            state_r <= eeprom_pkg::ST_RDATA;
          end else if (prot_hit(addr_w, bp_r)) begin
            state_r <= eeprom_pkg::ST_DEAD;
          end else begin
            state_r <= eeprom_pkg::ST_WDATA;
          end
        end
        eeprom_pkg::ST_RDATA: begin
          addr_r <= rd_addr_w;
        end
        eeprom_pkg::ST_WDATA: begin
          addr_r[eeprom_pkg::PAGE_BITS-1:0] <= addr_r[eeprom_pkg::PAGE_BITS-1:0] + 4'h1;
        end
        eeprom_pkg::ST_WSDATA: begin
          new_bp_r <= rx_nxt[eeprom_pkg::BP_LO_POS +: 2];
          state_r  <= eeprom_pkg::ST_ARMED;
          op_r     <= eeprom_pkg::OP_STATUS;
        end
        eeprom_pkg::ST_ARMED: begin
          state_r <= eeprom_pkg::ST_DEAD;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end else if (rise_ok && state_r == eeprom_pkg::ST_ARMED) begin
      state_r <= eeprom_pkg::ST_DEAD;
    end
  end

  // page buffer: later bytes at a wrapped slot overwrite earlier ones
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      page_r.valid <= '0;
    end else if (byte_done && state_r == eeprom_pkg::ST_ADDR) begin
      page_r.valid <= '0;
    end else if (byte_done && state_r == eeprom_pkg::ST_WDATA) begin
      page_r.data[addr_r[eeprom_pkg::PAGE_BITS-1:0]]  <= rx_nxt;
      page_r.valid[addr_r[eeprom_pkg::PAGE_BITS-1:0]] <= 1'b1;
    end
  end

  // writes start only on a select rise at an exact byte boundary
  assign start_stat_w = cs_rise && state_r == eeprom_pkg::ST_ARMED && op_r == eeprom_pkg::OP_STATUS
                        && wel_r && pin_s.wp_n;
  assign start_mem_w  = cs_rise && state_r == eeprom_pkg::ST_WDATA && bit_cnt_r == 3'd0
                        && (|page_r.valid) && wel_r && pin_s.wp_n;
  assign prog_end_w   = busy_r && prog_cnt_r == 32'd0;
  assign commit_w     = prog_end_w && kind_mem_r;

  // ---------------------------------------------------------------
  // transmit path: reload at each byte end, shift on falling edges
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || pin_s.cs_n) begin
      tx_r     <= 8'h00;
      tx_idx_r <= 3'd7;
      tx_arm_r <= 1'b0;
      drive_r  <= 1'b0;
      so_r     <= 1'b0;
    end else if (byte_done) begin
      tx_idx_r <= 3'd7;
      if ((state_r == eeprom_pkg::ST_CMD && cmd_w == eeprom_pkg::CMD_READ_STATUS)
          || state_r == eeprom_pkg::ST_RSTAT) begin
        tx_r     <= status_w;
        tx_arm_r <= 1'b1;
      end else if ((state_r == eeprom_pkg::ST_ADDR && !wr_mode_r) || state_r == eeprom_pkg::ST_RDATA) begin
        tx_r     <= mem_rd_w;
        tx_arm_r <= 1'b1;
      end
    end else if (fall_ok) begin
      so_r     <= tx_r[tx_idx_r];
      tx_idx_r <= tx_idx_r - 3'd1;
      drive_r  <= drive_r | tx_arm_r;
    end
  end

  assign so_o    = so_r;
  assign so_oe_o = drive_r & ~hold_r & ~pin_s.cs_n;

  // ---------------------------------------------------------------
  // program timer, protect bits and write latch
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      busy_r     <= 1'b0;
      kind_mem_r <= 1'b0;
      prog_cnt_r <= 32'd0;
      bp_r       <= eeprom_pkg::BP_RESET;
    end else if (busy_r) begin
      prog_cnt_r <= prog_cnt_r - 32'd1;
      if (prog_end_w) begin
        busy_r <= 1'b0;
        if (!kind_mem_r) begin
          bp_r <= new_bp_r;
        end
      end
    end else if (start_stat_w || start_mem_w) begin
      busy_r     <= 1'b1;
      kind_mem_r <= start_mem_w;
      prog_cnt_r <= 32'(PROGRAM_CYCLES - 1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wel_r <= 1'b0;
    end else if (!pin_s.wp_n || prog_end_w) begin
      wel_r <= 1'b0;
    end else if (cs_rise && state_r == eeprom_pkg::ST_ARMED) begin
      if (op_r == eeprom_pkg::OP_WL_SET) begin
        wel_r <= 1'b1;
      end else if (op_r == eeprom_pkg::OP_WL_CLR) begin
        wel_r <= 1'b0;
      end
    end
  end

  nv_array #(
    .ADDR_W (ADDR_W)
  ) u_array (
    .core_clk_i (core_clk_i),
    .rd_addr_i  (rd_addr_w),
    .rd_data_o  (mem_rd_w),
    .commit_i   (commit_w),
    .base_i     (addr_r[ADDR_W-1:eeprom_pkg::PAGE_BITS]),
    .page_i     (page_r)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_STATUS_REPEAT: assert property (
    (byte_done && state_r == eeprom_pkg::ST_RSTAT) |=> tx_r[7:4] == 4'hf && tx_r[1:0] == $past({wel_r, busy_r}))
    else $error("status byte not reloaded live");
  AST_BP_STABLE: assert property (
    (busy_r && !prog_end_w) |=> bp_r == $past(bp_r))
    else $error("protect bits changed mid-program");
  AST_WL_CLEAR_END: assert property (
    prog_end_w |=> !wel_r && !busy_r)
    else $error("latch or busy survived program end");
  AST_WP_CLEARS: assert property (
    !pin_s.wp_n |=> !wel_r)
    else $error("latch set with protect pin low");
  AST_BUSY_START: assert property (
    (start_stat_w || start_mem_w) |=> busy_r && prog_cnt_r == 32'(PROGRAM_CYCLES - 1))
    else $error("program did not start");
  AST_BUSY_REFUSE: assert property (
    (byte_done && state_r == eeprom_pkg::ST_CMD && busy_r && cmd_w == eeprom_pkg::CMD_READ)
    |=> state_r == eeprom_pkg::ST_DEAD)
    else $error("read accepted while busy");
  AST_READ_INC: assert property (
    (byte_done && state_r == eeprom_pkg::ST_RDATA) |=> addr_r == ADDR_W'($past(addr_r) + 1'b1))
    else $error("read address not incremented");
  AST_PAGE_WRAP: assert property (
    (byte_done && state_r == eeprom_pkg::ST_WDATA)
    |=> addr_r[ADDR_W-1:4] == $past(addr_r[ADDR_W-1:4]) && addr_r[3:0] == 4'($past(addr_r[3:0]) + 4'h1))
    else $error("page address did not wrap in place");
  AST_PROT_REJECT: assert property (
    (byte_done && state_r == eeprom_pkg::ST_ADDR && wr_mode_r && prot_hit(addr_w, bp_r))
    |=> state_r == eeprom_pkg::ST_DEAD)
    else $error("write to protected address accepted");
  AST_HOLD_FLOAT: assert property (
    hold_r |-> !so_oe_o && !rise_ok)
    else $error("activity during hold");
  AST_UNKNOWN_CMD: assert property (
    (state_r == eeprom_pkg::ST_DEAD && !pin_s.cs_n) |=> state_r == eeprom_pkg::ST_DEAD || pin_s.cs_n)
    else $error("left deselected state without select rise");

  COV_STATUS_WRITE: cover property (start_stat_w);
  COV_PAGE_WRITE: cover property (start_mem_w && page_r.valid == '1);
  COV_READ_WRAP: cover property (byte_done && state_r == eeprom_pkg::ST_RDATA && addr_r == '1);
  COV_HOLD: cover property ($rose(hold_r) ##[1:200] $fell(hold_r));
endmodule // serial_eeprom_command_engine

// >>> verif/serial_eeprom_command_engine_bench.sv
// self-checking bench for the serial eeprom command engine
// assumes the host model drives all serial pins; program time shortened
`timescale 1ns/1ps
module serial_eeprom_command_engine_bench;
  logic                 core_clk_i;
  logic                 sys_rst_i;
  logic                 so_o;
  logic                 so_oe_o;
  eeprom_pkg::pins_type pins;
  int                   n_errors    = 0;
  int                   check_count = 0;
  int                   cycles      = 0;
  logic [7:0]           rx;
  logic [7:0]           q[$];

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  serial_eeprom_command_engine #(
    .ADDR_W         (9),
    .PROGRAM_CYCLES (400)
  ) u_dut (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .cs_n_i     (pins.cs_n),
    .sck_i      (pins.sck),
    .si_i       (pins.si),
    .wp_n_i     (pins.wp_n),
    .hold_n_i   (pins.hold_n),
    .so_o       (so_o),
    .so_oe_o    (so_oe_o)
  );

  spi_host u_host (
    .core_clk_i (core_clk_i),
    .so_i       (so_o),
    .so_oe_i    (so_oe_o),
    .pins_o     (pins)
  );

  // ---------------------------------------------------------------
  // compares and closing
  // ---------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ceiling well above the expected run of some 6100 cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // serial operations
  // ---------------------------------------------------------------
  task automatic cmd(input logic [7:0] c);
    u_host.sel();
    u_host.xfer(c, rx);
    u_host.desel();
  endtask
  task automatic rd_stat(input logic [7:0] exp);
    u_host.sel();
    u_host.xfer(8'h05, rx);
    u_host.xfer(8'hff, rx);
    check8("status", exp, rx);
    u_host.xfer(8'hff, rx);
    check8("status repeat", exp, rx);
    u_host.desel();
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d[$]);
    u_host.sel();
    u_host.xfer({4'h0, a[8], 3'b010}, rx);
    u_host.xfer(a[7:0], rx);
    foreach (d[i]) u_host.xfer(d[i], rx);
    u_host.desel();
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp[$]);
    u_host.sel();
    u_host.xfer({4'h0, a[8], 3'b011}, rx);
    u_host.xfer(a[7:0], rx);
    foreach (exp[i]) begin
      u_host.xfer(8'h00, rx);
      check8("read data", exp[i], rx);
    end
    u_host.desel();
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    u_host.cyc(4);
    rd_stat(8'hf0);
    done("status after reset");
    cmd(8'h06);
    rd_stat(8'hf2);
    u_host.sel();
    u_host.xfer(8'h01, rx);
    u_host.xfer(8'h04, rx);
    u_host.desel();
    rd_stat(8'hf3);
    u_host.cyc(450);
    rd_stat(8'hf4);
    done("status write");
    cmd(8'h06);
    wr(9'h1f0, '{8'h55});
    u_host.cyc(450);
    rd_stat(8'hf6);
    wr(9'h00e, '{8'ha0, 8'ha1, 8'ha2});
    // a read issued while programming must leave the output released
    u_host.sel();
    u_host.xfer(8'h03, rx);
    u_host.xfer(8'h0e, rx);
    u_host.xfer(8'h00, rx);
    check8("output enable busy read", 8'h00, {7'h00, so_oe_o});
    u_host.desel();
    u_host.cyc(450);
    rd_stat(8'hf4);
    rd(9'h00e, '{8'ha0, 8'ha1, 8'hff});
    rd(9'h1ff, '{8'hff, 8'ha2});
    rd(9'h1f0, '{8'hff});
    done("memory write and read");
    cmd(8'h06);
    u_host.set_wp(1'b0);
    rd_stat(8'hf4);
    cmd(8'h06);
    u_host.sel();
    u_host.xfer(8'h01, rx);
    u_host.xfer(8'h00, rx);
    u_host.desel();
    u_host.cyc(450);
    u_host.set_wp(1'b1);
    rd_stat(8'hf4);
    done("write protect");
    u_host.sel();
    u_host.xfer(8'h05, rx);
    // let the first status bit go out before holding, so hold has a driver to float
    u_host.cyc(4);
    check8("output enable before hold", 8'h01, {7'h00, so_oe_o});
    u_host.set_hold(1'b0);
    check8("output enable in hold", 8'h00, {7'h00, so_oe_o});
    u_host.pulse();
    u_host.pulse();
    u_host.set_hold(1'b1);
    u_host.xfer(8'hff, rx);
    check8("status after hold", 8'hf4, rx);
    u_host.desel();
    done("hold");
    u_host.sel();
    u_host.xfer(8'h07, rx);
    u_host.xfer(8'hff, rx);
    check8("output enable unknown", 8'h00, {7'h00, so_oe_o});
    u_host.desel();
    rd_stat(8'hf4);
    done("unknown command");
    end_of_test();
  end
endmodule // serial_eeprom_command_engine_bench

// >>> verif/spi_host.sv
// host serial master model: select, clock, data, protect and hold pins
// assumes callers enter each task right after a core clock edge
`timescale 1ns/1ps
module spi_host (
  // clock
  input  wire logic            core_clk_i,
  // device output
  input  wire logic            so_i,
  input  wire logic            so_oe_i,
  // pins to device
  output eeprom_pkg::pins_type pins_o
);
  logic so_last = 1'b0;
  logic so_line;
  // ---------------------------------------------------------------
  // output line as the host sees it
  // ---------------------------------------------------------------
  // a released line shows the inverse of the last value, not a stale copy
  always_ff @(posedge core_clk_i) begin
    if (so_oe_i) so_last <= so_i;
  end
  assign so_line = so_oe_i ? so_i : ~so_last;
  initial begin
    pins_o = '{cs_n: 1'b1, sck: 1'b0, si: 1'b1, wp_n: 1'b1, hold_n: 1'b1};
  end
  // ---------------------------------------------------------------
  // pin sequences, sck period is eight core cycles
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic sel();
    pins_o.cs_n <= 1'b0;
    cyc(4);
  endtask
  // select rises with sck low, before any further rise
  task automatic desel();
    cyc(3);
    pins_o.cs_n <= 1'b1;
    cyc(6);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins_o.si <= tx[i];
      cyc(4);
      pins_o.sck <= 1'b1;
      rx[i] = so_line;
      cyc(4);
      pins_o.sck <= 1'b0;
    end
  endtask
  task automatic pulse();
    pins_o.sck <= 1'b1;
    cyc(4);
    pins_o.sck <= 1'b0;
    cyc(4);
  endtask
  task automatic set_wp(input logic v);
    pins_o.wp_n <= v;
    cyc(4);
  endtask
  // select is kept low for the whole hold
  task automatic set_hold(input logic v);
    pins_o.hold_n <= v;
    cyc(4);
  endtask
endmodule // spi_host
